// ===== rapd_pkg.sv
// package for the receive gain control power and peak detect block
// assumes one 200 MHz clock; all settings arrive as plain ports
package rapd_pkg;
  localparam int          CLK_MHZ       = 200;
  localparam logic [6:0]  IDX_WIDTH     = 7'h7F;   // weakest power reading; power capture start value
  localparam logic [7:0]  GAIN_IDX_MAX  = 8'hFF;
  localparam logic [7:0]  GAIN_IDX_MIN  = 8'h00;
  localparam logic [7:0]  GAIN_IDX_RST  = 8'hFF;
  localparam logic [6:0]  INNER_LVL_RST = 7'h07;
  localparam logic [3:0]  OUTER_OFS_RST = 4'h0;
  localparam logic [4:0]  OUTER_STEP_RST = 5'h04;
  localparam logic [5:0]  PEAK_UP_RST   = 6'h15;
  localparam logic [5:0]  PEAK_LO_RST   = 6'h0C;
  localparam logic [7:0]  UP_HIT_RST    = 8'h06;
  localparam logic [7:0]  LO_HIT_RST    = 8'h03;
  localparam logic [3:0]  GPIO_SEL_MAX  = 4'h9;
  localparam logic [3:0]  GPIO_SEL_NONE = 4'h0;
  localparam int          GPIO_PINS     = 16;
  localparam logic [4:0]  LEN_BASE_SHIFT = 5'h03;  // 8 samples = 1 << 3

  typedef enum logic [3:0] {
    RAPD_MEAS_IDLE  = 4'b0001,
    RAPD_MEAS_DELAY = 4'b0010,
    RAPD_MEAS_RUN   = 4'b0100,
    RAPD_MEAS_DONE  = 4'b1000
  } rapd_meas_t;

  // power detect settings
  typedef struct packed {
    logic [6:0]  inner_level;   // negative dBFS implied
    logic [3:0]  outer_offset;
    logic [4:0]  outer_step;
    logic [4:0]  inner_step;
    logic [6:0]  under_inner_level;
    logic [3:0]  meas_length_code;
    logic [15:0] tdd_length;
    logic [15:0] tdd_delay;
  } rapd_power_cfg_t;

  // peak detect settings
  typedef struct packed {
    logic [5:0]  upper_level;
    logic [5:0]  lower_level;
    logic [7:0]  upper_hits;
    logic [7:0]  lower_hits;
    logic [4:0]  attack_step;
    logic [4:0]  recovery_step;
    logic        block_gain_raise;
    logic [15:0] interval_low;
    logic [5:0]  interval_mid;
    logic [5:0]  interval_high;
  } rapd_peak_cfg_t;
endpackage

// ===== rapd_agc.sv
// receive gain control core: power measurement windows, peak counting,
// gain index pointer update and detector status onto gpio pin pairs
// assumes power level and peak samples are synchronous to ref_clk_in

// Summary of operation
// - tdd measure for length; zero runs to update
// - wait start delay after receive enable
// - inner power level is stable upper edge
// - outer edge is inner level plus offset
// - above outer edge, step down outer attack
// - between edges, step down inner attack
// - power status pair onto selected gpio pins
// - peak status pair onto selected gpio pins
// - fast recovery at low interval below low
// - mid interval is (mid+1) times low
// - high interval is (high+1) times mid
// - upper level hits flag overload, reduce gain
// - lower overload blocks raise in power mode
// - upper hit count raises high event, attack
// - lower hit count event; absence recovers gain
// - high event reduces index by attack step
// - measure 8 times two power code samples
// - under inner level is stable lower edge
module rapd_agc
  import rapd_pkg::*;
(
  input  wire logic             ref_clk_in,
  input  wire logic             rst_b_in,
  input  wire logic             tdd_mode_in,
  input  wire logic             power_mode_in,     // 1 power detect, 0 peak detect
  input  wire logic             agc_enable_in,
  input  wire logic             fast_recovery_in,
  input  wire logic             rx_enable_in,
  input  wire logic             update_tick_in,    // gain update counter expiry
  input  wire logic             sample_valid_in,   // iq sample strobe
  input  wire logic [6:0]       power_level_in,    // measured power, negative implied
  input  wire logic [5:0]       peak_level_in,
  input  wire logic             peak_valid_in,
  input  wire logic [13:0]      halfband_peak_in,
  input  wire logic [13:0]      halfband_under_low_level_in,
  input  wire logic [13:0]      halfband_under_mid_level_in,
  input  wire logic [13:0]      halfband_under_high_level_in,
  input  wire rapd_power_cfg_t  power_cfg_in,
  input  wire rapd_peak_cfg_t   peak_cfg_in,
  input  wire logic [3:0]       power_gpio_sel_in,
  input  wire logic [3:0]       peak_gpio_sel_in,
  output logic [7:0]            gain_index_out,
  output logic                  meas_active_out,
  output logic                  peak_high_event_out,
  output logic                  peak_low_event_out,
  output logic [GPIO_PINS-1:0]  digital_gpio_pin_out,
  output logic [GPIO_PINS-1:0]  digital_gpio_pin_oe_out
);

  rapd_meas_t  meas_q;
  logic [15:0] meas_cnt_q;
  logic [19:0] samp_cnt_q;
  logic        rx_en_q;
  logic [6:0]  pwr_q;          // strongest power seen in the window
  logic        pwr_seen_q;
  logic [7:0]  up_cnt_q;
  logic [7:0]  lo_cnt_q;
  logic        up_evt_q;
  logic        lo_evt_q;
  logic [31:0] rec_cnt_q;
  logic        rec_tick;
  logic [31:0] int_low;
  logic [31:0] int_mid;
  logic [31:0] int_high;
  logic [7:0]  outer_edge;
  logic        over_outer;
  logic        over_inner;
  logic        under_edge;
  logic [19:0] samp_target;
  logic        rx_rise;

  assign rx_rise     = rx_enable_in & ~rx_en_q;
  // offset is positive; levels are magnitudes of negative dBFS, so the outer
  // edge sits closer to full scale, i.e. a smaller magnitude
  assign outer_edge  = {1'b0, power_cfg_in.inner_level} - {4'h0, power_cfg_in.outer_offset};
  assign over_outer  = pwr_seen_q & ({1'b0, pwr_q} < outer_edge);
  assign over_inner  = pwr_seen_q & (pwr_q < power_cfg_in.inner_level) & ~over_outer;
  assign under_edge  = pwr_seen_q & (pwr_q > power_cfg_in.under_inner_level);
  assign samp_target = 20'h0_0001 << (5'(power_cfg_in.meas_length_code) + LEN_BASE_SHIFT);
  assign int_low     = {16'h0000, peak_cfg_in.interval_low};
  assign int_mid     = 32'(int_low * ({26'h0, peak_cfg_in.interval_mid} + 32'h0000_0001));
  assign int_high    = 32'(int_mid * ({26'h0, peak_cfg_in.interval_high} + 32'h0000_0001));

  // receive enable edge
  always_ff @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      rx_en_q <= 1'b0;
    else
      rx_en_q <= rx_enable_in;
  end

  // measurement window sequencer; non-tdd windows open at each update
  always_ff @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      meas_q     <= RAPD_MEAS_IDLE;
      meas_cnt_q <= 16'h0000;
      samp_cnt_q <= 20'h0_0000;
    end
    else
    begin
      case (meas_q)
        RAPD_MEAS_IDLE:
        begin
          samp_cnt_q <= 20'h0_0000;
          meas_cnt_q <= 16'h0000;
          if (tdd_mode_in && rx_rise)
          begin
            meas_q     <= (power_cfg_in.tdd_delay == 16'h0000) ? RAPD_MEAS_RUN
                                                               : RAPD_MEAS_DELAY;
          end
          else if (!tdd_mode_in && update_tick_in)
            meas_q <= RAPD_MEAS_RUN;
        end
        RAPD_MEAS_DELAY:
        begin
          meas_cnt_q <= meas_cnt_q + 16'h0001;
          if (meas_cnt_q == power_cfg_in.tdd_delay - 16'h0001)
          begin
            meas_cnt_q <= 16'h0000;
            meas_q     <= RAPD_MEAS_RUN;
          end
        end
        RAPD_MEAS_RUN:
        begin
          meas_cnt_q <= meas_cnt_q + 16'h0001;
          if (sample_valid_in)
            samp_cnt_q <= samp_cnt_q + 20'h0_0001;
          // zero length runs on until the gain update expiry; outside tdd the
          // expiry restarts the window so every update period gets a reading
          if (update_tick_in && !tdd_mode_in)
          begin
            meas_cnt_q <= 16'h0000;
            samp_cnt_q <= 20'h0_0000;
          end
          else if (update_tick_in)
            meas_q <= RAPD_MEAS_DONE;
          else if (tdd_mode_in && power_cfg_in.tdd_length != 16'h0000 &&
                   meas_cnt_q == power_cfg_in.tdd_length - 16'h0001)
            meas_q <= RAPD_MEAS_DONE;
          else if (!tdd_mode_in && sample_valid_in &&
                   samp_cnt_q == samp_target - 20'h0_0001)
            meas_q <= RAPD_MEAS_DONE;
        end
        RAPD_MEAS_DONE:
        begin
          meas_cnt_q <= 16'h0000;
          samp_cnt_q <= 20'h0_0000;
          if (!tdd_mode_in && update_tick_in)
            meas_q <= RAPD_MEAS_RUN;
          else if (update_tick_in || (tdd_mode_in && !rx_enable_in))
            meas_q <= RAPD_MEAS_IDLE;
        end
        default:
          meas_q <= RAPD_MEAS_IDLE;
      endcase
    end
  end

  // power capture: keep the strongest (smallest magnitude) reading in the window
  always_ff @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      pwr_q      <= IDX_WIDTH;
      pwr_seen_q <= 1'b0;
    end
    else if (update_tick_in)
    begin
      pwr_q      <= IDX_WIDTH;
      pwr_seen_q <= 1'b0;
    end
    else if (meas_q == RAPD_MEAS_RUN && sample_valid_in)
    begin
      pwr_seen_q <= 1'b1;
      if (!pwr_seen_q || power_level_in < pwr_q)
        pwr_q <= power_level_in;
    end
  end

  // peak counters per gain update period; saturate rather than wrap
  always_ff @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      up_cnt_q <= 8'h00;
      lo_cnt_q <= 8'h00;
      up_evt_q <= 1'b0;
      lo_evt_q <= 1'b0;
    end
    else if (update_tick_in)
    begin
      // a peak landing on the expiry counts toward the new period
      up_cnt_q <= {7'h00, peak_valid_in && peak_level_in > peak_cfg_in.upper_level};
      lo_cnt_q <= {7'h00, peak_valid_in && peak_level_in > peak_cfg_in.lower_level};
      up_evt_q <= 1'b0;
      lo_evt_q <= 1'b0;
    end
    else
    begin
      if (peak_valid_in && peak_level_in > peak_cfg_in.upper_level && up_cnt_q != 8'hFF)
        up_cnt_q <= up_cnt_q + 8'h01;
      if (peak_valid_in && peak_level_in > peak_cfg_in.lower_level && lo_cnt_q != 8'hFF)
        lo_cnt_q <= lo_cnt_q + 8'h01;
      if (up_cnt_q >= peak_cfg_in.upper_hits && up_cnt_q != 8'h00)
        up_evt_q <= 1'b1;
      if (lo_cnt_q >= peak_cfg_in.lower_hits && lo_cnt_q != 8'h00)
        lo_evt_q <= 1'b1;
    end
  end

  // fast recovery timer; interval picked by how low the halfband peaks sit
  always_ff @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      rec_cnt_q <= 32'h0000_0000;
    else if (rec_tick || !fast_recovery_in || power_mode_in)
      rec_cnt_q <= 32'h0000_0000;
    else
      rec_cnt_q <= rec_cnt_q + 32'h0000_0001;
  end

  always_comb
  begin
    rec_tick = 1'b0;
    if (fast_recovery_in && !power_mode_in && !up_evt_q)
    begin
      if (halfband_peak_in < halfband_under_low_level_in)
        rec_tick = (rec_cnt_q + 32'h0000_0001 >= int_low) && (int_low != 32'h0);
      else if (halfband_peak_in < halfband_under_mid_level_in)
        rec_tick = (rec_cnt_q + 32'h0000_0001 >= int_mid) && (int_mid != 32'h0);
      else if (halfband_peak_in < halfband_under_high_level_in)
        rec_tick = (rec_cnt_q + 32'h0000_0001 >= int_high) && (int_high != 32'h0);
    end
  end

  // gain index pointer: decrease is attack, increase is recovery
  always_ff @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      gain_index_out <= GAIN_IDX_RST;
    else if (agc_enable_in && (update_tick_in || rec_tick))
    begin : upd
      logic [9:0] nxt;
      nxt = {2'b00, gain_index_out};
      if (update_tick_in && (up_evt_q || (up_cnt_q >= peak_cfg_in.upper_hits && up_cnt_q != 8'h00)))
        nxt = nxt - {5'h00, peak_cfg_in.attack_step};
      else if (update_tick_in && power_mode_in && over_outer)
        nxt = nxt - {5'h00, power_cfg_in.outer_step};
      else if (update_tick_in && power_mode_in && over_inner)
        nxt = nxt - {5'h00, power_cfg_in.inner_step};
      else if (update_tick_in && !power_mode_in && !lo_evt_q && !fast_recovery_in)
        nxt = nxt + {5'h00, peak_cfg_in.recovery_step};
      else if (rec_tick && !lo_evt_q)
        nxt = nxt + {5'h00, peak_cfg_in.recovery_step};
      else if (update_tick_in && power_mode_in && under_edge &&
               !(peak_cfg_in.block_gain_raise && lo_evt_q))
        nxt = nxt + 10'h001;
      // borrow wraps into bit 9; clamp into the table
      if (nxt[9])
        gain_index_out <= GAIN_IDX_MIN;
      else if (nxt[8])
        gain_index_out <= GAIN_IDX_MAX;
      else
        gain_index_out <= nxt[7:0];
    end
  end

  // status flags and measurement activity
  always_ff @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      meas_active_out     <= 1'b0;
      peak_high_event_out <= 1'b0;
      peak_low_event_out  <= 1'b0;
    end
    else
    begin
      meas_active_out     <= (meas_q == RAPD_MEAS_RUN);
      peak_high_event_out <= up_evt_q;
      peak_low_event_out  <= lo_evt_q;
    end
  end

  // gpio routing: code n selects pins 2n-4.. pair, code 9 gives 14 and 15
  genvar g;
  generate
    for (g = 0; g < GPIO_PINS / 2; g++)
    begin : gpio_pair
      localparam logic [3:0] CODE = 4'(g + 2);
      always_ff @(posedge ref_clk_in or negedge rst_b_in)
      begin
        if (!rst_b_in)
        begin
          digital_gpio_pin_out[2*g+1:2*g]    <= 2'b00;
          digital_gpio_pin_oe_out[2*g+1:2*g] <= 2'b00;
        end
        else if (power_gpio_sel_in == CODE && CODE <= GPIO_SEL_MAX)
        begin
          digital_gpio_pin_out[2*g+1:2*g]    <= {over_inner | over_outer, under_edge};
          digital_gpio_pin_oe_out[2*g+1:2*g] <= 2'b11;
        end
        else if (peak_gpio_sel_in == CODE && CODE <= GPIO_SEL_MAX)
        begin
          digital_gpio_pin_out[2*g+1:2*g]    <= {up_evt_q, lo_evt_q};
          digital_gpio_pin_oe_out[2*g+1:2*g] <= 2'b11;
        end
        else
        begin
          digital_gpio_pin_out[2*g+1:2*g]    <= 2'b00;
          digital_gpio_pin_oe_out[2*g+1:2*g] <= 2'b00;
        end
      end
    end
  endgenerate

  // the tdd window must close by the programmed length
  chk_tdd_len_bound: assert property (
    @(posedge ref_clk_in) disable iff (!rst_b_in)
    (meas_q == RAPD_MEAS_RUN && tdd_mode_in && power_cfg_in.tdd_length != 16'h0000)
    |-> meas_cnt_q < power_cfg_in.tdd_length)
    else $error("tdd window overran length");
  chk_tdd_delay_wait: assert property (
    @(posedge ref_clk_in) disable iff (!rst_b_in)
    (meas_q == RAPD_MEAS_IDLE && tdd_mode_in && rx_rise && power_cfg_in.tdd_delay == 16'h0002)
    |=> meas_q == RAPD_MEAS_DELAY ##1 meas_q == RAPD_MEAS_DELAY)
    else $error("start delay too short");
  chk_gain_clamp: assert property (
    @(posedge ref_clk_in) disable iff (!rst_b_in)
    (update_tick_in && agc_enable_in && up_evt_q &&
     gain_index_out < {3'b000, peak_cfg_in.attack_step})
    |=> gain_index_out == GAIN_IDX_MIN)
    else $error("gain index not clamped");
  chk_peak_attack: assert property (
    @(posedge ref_clk_in) disable iff (!rst_b_in)
    (update_tick_in && agc_enable_in && up_evt_q && gain_index_out >= 8'h20)
    |=> gain_index_out == $past(gain_index_out) - 8'($past(peak_cfg_in.attack_step)))
    else $error("attack step not applied");
  chk_gpio_none: assert property (
    @(posedge ref_clk_in) disable iff (!rst_b_in)
    (power_gpio_sel_in == GPIO_SEL_NONE && peak_gpio_sel_in == GPIO_SEL_NONE)
    |=> digital_gpio_pin_oe_out == '0)
    else $error("gpio driven while unassigned");
  chk_pair_nine: assert property (
    @(posedge ref_clk_in) disable iff (!rst_b_in)
    (peak_gpio_sel_in == GPIO_SEL_MAX && power_gpio_sel_in != GPIO_SEL_MAX)
    |=> digital_gpio_pin_oe_out[15:14] == 2'b11 && digital_gpio_pin_out[15] == $past(up_evt_q))
    else $error("pair nine not on pins 14 15");
  chk_high_flag: assert property (
    @(posedge ref_clk_in) disable iff (!rst_b_in)
    (!update_tick_in && up_cnt_q >= peak_cfg_in.upper_hits && up_cnt_q != 8'h00)
    |=> up_evt_q ##1 peak_high_event_out)
    else $error("high overload not flagged");
  chk_outer_step: assert property (
    @(posedge ref_clk_in) disable iff (!rst_b_in)
    (update_tick_in && agc_enable_in && power_mode_in && !up_evt_q && over_outer &&
     up_cnt_q == 8'h00 && gain_index_out >= 8'h20)
    |=> gain_index_out == $past(gain_index_out) - 8'($past(power_cfg_in.outer_step)))
    else $error("outer attack not applied");

endmodule

// ===== rapd_bb_monitor.sv
// baseband side model: watches the digital gpio pins of the gain block
// assumes no pull resistors on the pins and one clock shared with the block
module rapd_bb_monitor
  import rapd_pkg::*;
(
  input  wire logic [GPIO_PINS-1:0] pin_drive_in,
  input  wire logic [GPIO_PINS-1:0] pin_oe_in,
  input  wire logic                 ref_clk_in,
  output logic [GPIO_PINS-1:0]      pin_level_out,
  output logic [1:0]                top_pair_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [GPIO_PINS-1:0] last_q = '0;

  // an undriven pin shows the inverse of its last level, so stale data never passes
  always_comb
  begin
    for (int i = 0; i < GPIO_PINS; i++)
      pin_level_out[i] = pin_oe_in[i] ? pin_drive_in[i] : ~last_q[i];
  end

  // remember the level each edge; undriven pins then toggle every cycle
  always_ff @(posedge ref_clk_in)
    last_q <= pin_level_out;

  // the processor reads the status pair on the top two pins
  assign top_pair_out = pin_level_out[15:14];
endmodule

// ===== rapd_agc_bench.sv
// self-checking bench for the gain control block
// assumes one 200 MHz clock; inputs change on the falling edge
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module rapd_agc_bench
  import rapd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic            ref_clk_in = 1'b0;
  logic            rst_b_in   = 1'b0;
  logic            tdd_mode, power_mode, agc_en, fast_rec, rx_en, upd_tick, smp_vld, pk_vld;
  logic [6:0]      pwr_lvl;
  logic [5:0]      pk_lvl;
  logic [13:0]     hb_pk, hb_lo, hb_mid, hb_hi;
  rapd_power_cfg_t pcfg;
  rapd_peak_cfg_t  kcfg;
  logic [3:0]      psel, ksel;
  logic [7:0]      gain, exp_g;
  logic            meas, ev_hi, ev_lo;
  logic [15:0]     gp, gp_oe, pin_lvl;
  logic [1:0]      pair;
  int              errors = 0;
  int              n_checks = 0;
  int              cyc = 0;

  rapd_agc dut (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .tdd_mode_in(tdd_mode),
    .power_mode_in(power_mode), .agc_enable_in(agc_en), .fast_recovery_in(fast_rec),
    .rx_enable_in(rx_en), .update_tick_in(upd_tick), .sample_valid_in(smp_vld),
    .power_level_in(pwr_lvl), .peak_level_in(pk_lvl), .peak_valid_in(pk_vld),
    .halfband_peak_in(hb_pk), .halfband_under_low_level_in(hb_lo),
    .halfband_under_mid_level_in(hb_mid), .halfband_under_high_level_in(hb_hi),
    .power_cfg_in(pcfg), .peak_cfg_in(kcfg), .power_gpio_sel_in(psel),
    .peak_gpio_sel_in(ksel), .gain_index_out(gain), .meas_active_out(meas),
    .peak_high_event_out(ev_hi), .peak_low_event_out(ev_lo),
    .digital_gpio_pin_out(gp), .digital_gpio_pin_oe_out(gp_oe));

  rapd_bb_monitor bb (.pin_drive_in(gp), .pin_oe_in(gp_oe), .ref_clk_in(ref_clk_in),
    .pin_level_out(pin_lvl), .top_pair_out(pair));

  always #2.5 ref_clk_in = ~ref_clk_in;

  // hang guard: the whole run needs far fewer cycles than this
  always @(posedge ref_clk_in)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      errors++;
      conclude();
    end
  end

  task automatic conclude();
    if (errors == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic cyc_n(input int n);
    repeat (n) @(negedge ref_clk_in);
  endtask

  // short reset between scenarios; outputs are checked while it is held
  task automatic do_reset();
    rst_b_in = 1'b0;
    cyc_n(2);
    `CHK(gain, GAIN_IDX_RST)
    `CHK({meas, ev_hi, ev_lo, gp_oe}, 19'h0_0000)
    rst_b_in = 1'b1;
    exp_g = GAIN_IDX_RST;
  endtask

  task automatic tick();
    upd_tick = 1'b1;
    cyc_n(1);
    upd_tick = 1'b0;
    cyc_n(2);
  endtask

  task automatic feed(input logic [6:0] lvl, input int n);
    repeat (n)
    begin
      pwr_lvl = lvl;
      smp_vld = 1'b1;
      cyc_n(1);
      smp_vld = 1'b0;
      cyc_n(1);
    end
  endtask

  task automatic peaks(input logic [5:0] lvl, input int n);
    repeat (n)
    begin
      pk_lvl = lvl;
      pk_vld = 1'b1;
      cyc_n(1);
      pk_vld = 1'b0;
      cyc_n(1);
    end
    cyc_n(3);
  endtask

  // cycles until the gain pointer next moves
  task automatic gap(output int n);
    logic [7:0] g0;
    g0 = gain;
    n = 0;
    while (gain === g0 && n < 300)
    begin
      cyc_n(1);
      n++;
    end
  endtask

  // boundary levels around inner 20, outer 15 and under 40; one strong sample decides
  task automatic s_power();
    logic [6:0] lv [5] = '{7'h14, 7'h0E, 7'h0F, 7'h32, 7'h28};
    logic [7:0] ex [5] = '{8'hFF, 8'hFB, 8'hF9, 8'hFA, 8'hFA};
    do_reset();
    power_mode = 1'b1;
    tick();
    for (int i = 0; i < 5; i++)
    begin
      feed(7'h32, 7);
      feed(lv[i], 1);
      tick();
      `CHK(gain, ex[i])
    end
    feed(7'h32, 8);
    feed(7'h0E, 1);
    tick();
    `CHK(gain, 8'hFB)
    feed(7'h0E, 8);
    agc_en = 1'b0;
    tick();
    `CHK(gain, 8'hFB)
    agc_en = 1'b1;
  endtask

  task automatic s_tdd();
    int k;
    int m;
    do_reset();
    tdd_mode = 1'b1;
    rx_en = 1'b1;
    k = 0;
    while (meas !== 1'b1 && k < 40)
    begin
      cyc_n(1);
      k++;
    end
    // delay, plus the edge that sees rx enable and the output register
    `CHK(k, int'(pcfg.tdd_delay) + 2)
    m = 0;
    while (meas === 1'b1 && m < 40)
    begin
      cyc_n(1);
      m++;
    end
    `CHK(m, 10)
    rx_en = 1'b0;
    pcfg.tdd_length = 16'h0000;
    cyc_n(3);
    rx_en = 1'b1;
    cyc_n(40);
    `CHK(meas, 1'b1)
    tick();
    `CHK(meas, 1'b0)
    rx_en = 1'b0;
    tdd_mode = 1'b0;
  endtask

  task automatic s_peak();
    do_reset();
    power_mode = 1'b0;
    ksel = 4'h9;
    peaks(6'h1E, 2);
    `CHK({ev_hi, ev_lo}, 2'b01)
    peaks(6'h1E, 1);
    `CHK({ev_hi, gp_oe, pair}, 19'h7_0003)
    tick();
    `CHK({gain, ev_hi, ev_lo}, 10'h3E8)
    peaks(6'h0F, 2);
    `CHK({ev_hi, ev_lo}, 2'b01)
    tick();
    `CHK(gain, 8'hFA)
    tick();
    `CHK(gain, 8'hFD)
    tick();
    `CHK({gain, pair}, 10'h3FC)
    ksel = 4'h0;
    cyc_n(3);
    `CHK(gp_oe, 16'h0000)
    psel = 4'h9;
    ksel = 4'h9;
    cyc_n(3);
    `CHK(gp_oe, 16'hC000)
    psel = 4'h0;
    ksel = 4'h0;
  endtask

  // drive the pointer to the floor, then time the recovery steps
  task automatic s_fast();
    int n;
    int ex [3] = '{8, 16, 32};
    logic [13:0] hv [3] = '{14'h0000, 14'h0096, 14'h00FA};
    do_reset();
    power_mode = 1'b0;
    kcfg.upper_hits = 8'h01;
    kcfg.lower_hits = 8'h01;
    kcfg.attack_step = 5'h1F;
    for (int i = 0; i < 9; i++)
    begin
      peaks(6'h1E, 1);
      tick();
      exp_g = (exp_g > 8'h1F) ? exp_g - 8'h1F : 8'h00;
      `CHK(gain, exp_g)
    end
    fast_rec = 1'b1;
    for (int j = 0; j < 3; j++)
    begin
      hb_pk = hv[j];
      gap(n);
      gap(n);
      `CHK(n, ex[j])
    end
    fast_rec = 1'b0;
  endtask

  task automatic s_block();
    do_reset();
    power_mode = 1'b1;
    kcfg.block_gain_raise = 1'b1;
    psel = 4'h9;
    tick();
    feed(7'h0E, 8);
    `CHK(pair, 2'b10)
    tick();
    `CHK(gain, 8'hFB)
    feed(7'h32, 8);
    peaks(6'h0F, 2);
    tick();
    `CHK(gain, 8'hFB)
    feed(7'h32, 8);
    tick();
    `CHK(gain, 8'hFC)
  endtask

  initial
  begin
    {tdd_mode, power_mode, fast_rec, rx_en, upd_tick, smp_vld, pk_vld} = 7'h00;
    agc_en = 1'b1;
    {pwr_lvl, pk_lvl, hb_pk} = '0;
    hb_lo = 14'h0064;
    hb_mid = 14'h00C8;
    hb_hi = 14'h012C;
    {psel, ksel} = 8'h00;
    pcfg = '{inner_level: 7'h14, outer_offset: 4'h5, outer_step: 5'h04, inner_step: 5'h02,
      under_inner_level: 7'h28, meas_length_code: 4'h0, tdd_length: 16'h000A,
      tdd_delay: 16'h0002};
    kcfg = '{upper_level: 6'h15, lower_level: 6'h0C, upper_hits: 8'h03, lower_hits: 8'h02,
      attack_step: 5'h05, recovery_step: 5'h03, block_gain_raise: 1'b0,
      interval_low: 16'h0008, interval_mid: 6'h01, interval_high: 6'h01};
    cyc_n(16);
    rst_b_in = 1'b1;
    s_power();
    s_tdd();
    s_peak();
    s_block();
    s_fast();
    conclude();
  end
endmodule
